/* logic/adc_channel_sequencer.sv */
// channel sequencer, serial word framing and ahb-lite register file of the converter
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
module adc_channel_sequencer import adc_seq_pkg::*; (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// serial pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	output logic dout,
	output logic dout_oe_n,
	// analog front end
	input wire logic cmp_in,
	output logic [CODE_W-1:0] dac_code,
	output logic [CH_W-1:0] mux_sel,
	output logic range_sel
);
	// pin synchronisers: {cmp, din, sclk, cs_n}
	logic [3:0] s1_ff;
	logic [3:0] s2_ff;
	logic [3:0] s3_ff;
	logic cs_fall;
	logic cs_rise;
	logic sclk_fall;
	logic in_xfer_ff;
	logic [4:0] cnt_ff;
	logic [WORD_W-1:0] rx_ff;
	logic [WORD_W-1:0] nxt_rx;
	logic end_pulse;
	// sequencer state
	seq_mode_e mode_ff;
	logic first_ff;
	logic [CTRL_W-1:0] ctrl_ff;
	logic [WORD_W-1:0] mask_ff;
	logic [CH_W-1:0] cur_ch_ff;
	logic [CH_W-1:0] nxt_ch;
	logic [CH_W-1:0] last_ch;
	logic twos_ff;
	logic ser_ctrl;
	logic sw_ctrl;
	logic wr_ctrl;
	logic [CTRL_W-1:0] wr_val;
	logic mask_load;
	// output path
	logic [CODE_W-1:0] sar_res;
	logic [CODE_W-1:0] sar_trial;
	logic [CODE_W-1:0] code_out;
	logic [WORD_W-1:0] word;
	logic dout_ff;
	logic oe_n_ff;
	logic range_ff;
	logic [WORD_W-1:0] last_word_ff;
	// bus
	logic ap;
	logic wr_pend_ff;
	logic [7:0] waddr_ff;
	logic [31:0] rdata_ff;
	logic [31:0] rd_mux;
	logic hreadyout_ff;

	// lowest set bit above c, or lowest set bit when from_start or none above
	function automatic logic [CH_W-1:0] next_set(input logic [WORD_W-1:0] m,
			input logic [CH_W-1:0] c, input logic from_start);
		logic [CH_W-1:0] lo;
		logic [CH_W-1:0] up;
		logic got;
		lo = '0;
		up = '0;
		got = 1'b0;
		for (int i = WORD_W - 1; i >= 0; i--) begin
			if (m[i]) begin
				lo = CH_W'(i);
				if (!from_start && CH_W'(i) > c) begin
					up = CH_W'(i);
					got = 1'b1;
				end
			end
		end
		return got ? up : lo;
	endfunction : next_set

	// pins are asynchronous to hclk
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_ff <= SYNC_RST;
			s2_ff <= SYNC_RST;
			s3_ff <= SYNC_RST;
		end else begin
			s1_ff <= {cmp_in, din, sclk, cs_n};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// edge detection needs sclk well below hclk/4
	assign cs_fall = s3_ff[0] && !s2_ff[0];
	assign cs_rise = !s3_ff[0] && s2_ff[0];
	assign sclk_fall = s3_ff[1] && !s2_ff[1] && !s2_ff[0] && in_xfer_ff;
	assign nxt_rx = {rx_ff[WORD_W-2:0], s2_ff[2]};
	assign end_pulse = sclk_fall && cnt_ff == XFER_LAST;

	// transfer framing, sixteen falling edges per conversion
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_xfer_ff <= 1'b0;
			cnt_ff <= '0;
			rx_ff <= '0;
		end else if (cs_fall) begin
			in_xfer_ff <= 1'b1;
			cnt_ff <= '0;
		end else if (cs_rise) begin
			in_xfer_ff <= 1'b0;
		end else if (sclk_fall) begin
			rx_ff <= nxt_rx;
			cnt_ff <= cnt_ff + 5'h01;
			if (end_pulse) begin
				in_xfer_ff <= 1'b0;
			end
		end
	end

	// an aborted transfer writes nothing; control only lands on the 16th edge
	assign ser_ctrl = end_pulse && mode_ff != SEQ_MASK_ARM && nxt_rx[WORD_W-1];
	assign mask_load = end_pulse && mode_ff == SEQ_MASK_ARM;
	assign sw_ctrl = wr_pend_ff && waddr_ff == A_CTRL;
	assign wr_ctrl = ser_ctrl || sw_ctrl;
	assign wr_val = ser_ctrl ? nxt_rx[WORD_W-1:WORD_W-CTRL_W] : hwdata[CTRL_W-1:0];
	assign last_ch = ctrl_ff[CB_ADDR_LO +: CH_W];

	// mode and control register, serial write wins over a bus write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= CTRL_RST;
			mode_ff <= SEQ_SINGLE;
			first_ff <= 1'b0;
			mask_ff <= '0;
		end else begin
			if (cs_fall) begin
				first_ff <= 1'b0;
			end
			if (mask_load) begin
				for (int i = 0; i < WORD_W; i++) begin
					mask_ff[i] <= nxt_rx[WORD_W-1-i];
				end
				mode_ff <= SEQ_MASK_RUN;
				first_ff <= 1'b1;
			end else if (wr_ctrl) begin
				ctrl_ff <= wr_val;
				case (wr_val[CB_MASK_SEL +: 2])
					SEQ_KEEP: begin
						mode_ff <= mode_ff;
					end
					SEQ_MASK: begin
						mode_ff <= SEQ_MASK_ARM;
					end
					SEQ_CONS: begin
						mode_ff <= SEQ_CONSEC;
						first_ff <= 1'b1;
					end
					default: begin
						mode_ff <= SEQ_SINGLE;
					end
				endcase
			end
		end
	end

	// channel for the conversion that a chip select falling edge starts
	always_comb begin
		nxt_ch = last_ch;
		case (mode_ff)
			SEQ_MASK_RUN: begin
				if (mask_ff != '0) begin
					nxt_ch = next_set(mask_ff, cur_ch_ff, first_ff);
				end
			end
			SEQ_CONSEC: begin
				if (first_ff || cur_ch_ff >= last_ch) begin
					nxt_ch = '0;
				end else begin
					nxt_ch = cur_ch_ff + 4'h1;
				end
			end
			default: begin
				nxt_ch = last_ch;
			end
		endcase
	end

	// channel and coding are frozen for the whole conversion
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur_ch_ff <= '0;
			twos_ff <= 1'b0;
		end else if (cs_fall) begin
			cur_ch_ff <= nxt_ch;
			twos_ff <= !ctrl_ff[CB_CODING];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			range_ff <= 1'b0;
		end else begin
			range_ff <= ctrl_ff[CB_RANGE];
		end
	end

	sar_stepper u_sar (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(cs_fall),
		.step(sclk_fall && cnt_ff < SAR_STEPS),
		.cmp(s2_ff[3]),
		.trial(sar_trial),
		.result(sar_res)
	);

	// msb flip turns offset binary into two's complement about the midpoint
	assign code_out = {sar_res[CODE_W-1] ^ twos_ff, sar_res[CODE_W-2:0]};
	assign word = {cur_ch_ff, code_out};

	// code bit k is decided three edges before it is shifted out
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dout_ff <= 1'b0;
			oe_n_ff <= 1'b1;
		end else if (cs_fall) begin
			dout_ff <= nxt_ch[CH_W-1];
			oe_n_ff <= 1'b0;
		end else if (cs_rise || end_pulse) begin
			dout_ff <= 1'b0;
			oe_n_ff <= 1'b1;
		end else if (sclk_fall) begin
			dout_ff <= word[4'(5'h0e - cnt_ff)];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_word_ff <= '0;
		end else if (end_pulse) begin
			last_word_ff <= word;
		end
	end

	// ahb-lite: zero wait states, always okay
	assign ap = hsel && htrans[1] && hready;

	always_comb begin
		case (haddr[7:0])
			A_CTRL: rd_mux = {20'h00000, ctrl_ff};
			A_MASK: rd_mux = {16'h0000, mask_ff};
			A_STATUS: rd_mux = {24'h000000, mode_ff, first_ff, in_xfer_ff, cur_ch_ff};
			A_RESULT: rd_mux = {16'h0000, last_word_ff};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			waddr_ff <= '0;
			rdata_ff <= '0;
			hreadyout_ff <= 1'b1;
		end else begin
			hreadyout_ff <= 1'b1;
			wr_pend_ff <= ap && hwrite;
			if (ap) begin
				waddr_ff <= haddr[7:0];
			end
			if (ap && !hwrite) begin
				rdata_ff <= rd_mux;
			end
		end
	end

	assign hrdata = rdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = 1'b0;
	assign dout = dout_ff;
	assign dout_oe_n = oe_n_ff;
	assign dac_code = sar_trial;
	assign mux_sel = cur_ch_ff;
	assign range_sel = range_ff;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_SINGLE_CH: assert property (cs_fall && mode_ff == SEQ_SINGLE
		|=> cur_ch_ff == $past(last_ch))
		else $error("single channel not taken from address bits");
	AST_CONS_START: assert property (cs_fall && mode_ff == SEQ_CONSEC && first_ff
		|=> cur_ch_ff == 4'h0)
		else $error("consecutive run did not start at channel 0");
	AST_CONS_STEP: assert property (cs_fall && mode_ff == SEQ_CONSEC && !first_ff
		&& cur_ch_ff < last_ch |=> cur_ch_ff == $past(cur_ch_ff) + 4'h1)
		else $error("consecutive run did not step by one");
	AST_CONS_WRAP: assert property (cs_fall && mode_ff == SEQ_CONSEC && !first_ff
		&& cur_ch_ff >= last_ch |=> cur_ch_ff == 4'h0)
		else $error("consecutive run did not wrap to channel 0");
	AST_MASK_FIRST: assert property (cs_fall && mode_ff == SEQ_MASK_RUN && first_ff
		&& mask_ff != '0 |=> mask_ff[cur_ch_ff]
		&& (mask_ff & ((16'h0001 << cur_ch_ff) - 16'h0001)) == '0)
		else $error("mask run did not start at lowest channel");
	AST_MASK_NEXT: assert property (cs_fall && mode_ff == SEQ_MASK_RUN && mask_ff != '0
		|=> mask_ff[cur_ch_ff])
		else $error("mask run converted an unmasked channel");
	AST_ABORT: assert property (ser_ctrl && !mask_load
		&& nxt_rx[WORD_W-1-CTRL_W+CB_MASK_SEL+2 -: 2] != SEQ_KEEP
		&& nxt_rx[WORD_W-1-CTRL_W+CB_MASK_SEL+2 -: 2] != SEQ_CONS
		|=> mode_ff != SEQ_MASK_RUN && mode_ff != SEQ_CONSEC)
		else $error("sequence not ended by control write");
	AST_CTRL_CAP: assert property (ser_ctrl |=> ctrl_ff == $past(nxt_rx[WORD_W-1 -: CTRL_W]))
		else $error("control word not captured from first twelve bits");
	AST_MASK_LOAD: assert property (mask_load
		|=> mode_ff == SEQ_MASK_RUN && mask_ff[0] == $past(nxt_rx[WORD_W-1]))
		else $error("mask not loaded first bit to channel 0");
	AST_TAG_FIRST: assert property (cs_fall |=> !dout_oe_n && dout == cur_ch_ff[CH_W-1])
		else $error("channel tag msb not first on serial out");
	AST_RANGE: assert property (##1 range_sel == $past(ctrl_ff[CB_RANGE]))
		else $error("range select does not follow control bit");
endmodule : adc_channel_sequencer

/* common/adc_seq_pkg.sv */
// constants and types shared by the channel sequencer and its sar stepper
package adc_seq_pkg;
	localparam int CH_W = 4;
	localparam int CODE_W = 12;
	localparam int WORD_W = 16;
	localparam int CTRL_W = 12;
	// control word field positions, first serial bit is bit 11
	localparam int CB_WRITE = 11;
	localparam int CB_SEQ = 10;
	localparam int CB_MASK_SEL = 9;
	localparam int CB_ADDR_LO = 4;
	localparam int CB_PM_LO = 2;
	localparam int CB_RANGE = 1;
	localparam int CB_CODING = 0;
	localparam logic [CTRL_W-1:0] CTRL_RST = 12'h00c;
	localparam logic [1:0] SEQ_KEEP = 2'h2;
	localparam logic [1:0] SEQ_MASK = 2'h1;
	localparam logic [1:0] SEQ_CONS = 2'h3;
	// serial framing
	localparam logic [4:0] XFER_LAST = 5'h0f;
	localparam logic [4:0] SAR_STEPS = 5'h0c;
	localparam logic [3:0] SYNC_RST = 4'h3;
	localparam logic [CODE_W-1:0] SAR_FIRST = 12'h800;
	localparam logic [3:0] SAR_MSB = 4'hb;
	// bus map
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_MASK = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h08;
	localparam logic [7:0] A_RESULT = 8'h0c;
	typedef enum logic [1:0] {
		SEQ_SINGLE,
		SEQ_MASK_ARM,
		SEQ_MASK_RUN,
		SEQ_CONSEC
	} seq_mode_e;
endpackage : adc_seq_pkg

/* logic/sar_stepper.sv */
// successive-approximation register stepped by serial clock falling edges
module sar_stepper import adc_seq_pkg::*; (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// control
	input wire logic start,
	input wire logic step,
	input wire logic cmp,
	// trial code and result
	output logic [CODE_W-1:0] trial,
	output logic [CODE_W-1:0] result
);
	logic [CODE_W-1:0] trial_ff;
	logic [CODE_W-1:0] res_ff;
	logic [3:0] bit_ff;
	logic [CODE_W-1:0] nxt_res;
	logic [CODE_W-1:0] nxt_trial;

	assign trial = trial_ff;
	assign result = res_ff;

	// trial weights are ref/4096 each; the half-step offset sits in the dac
	always_comb begin
		nxt_res = res_ff;
		nxt_res[bit_ff] = cmp;
		nxt_trial = nxt_res;
		if (bit_ff != 4'h0) begin
			nxt_trial[bit_ff - 4'h1] = 1'b1;
		end
	end

	// one bit decided per serial clock falling edge, on the first twelve edges of a transfer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trial_ff <= SAR_FIRST;
			res_ff <= '0;
			bit_ff <= SAR_MSB;
		end else if (start) begin
			trial_ff <= SAR_FIRST;
			res_ff <= '0;
			bit_ff <= SAR_MSB;
		end else if (step) begin
			res_ff <= nxt_res;
			trial_ff <= nxt_trial;
			bit_ff <= bit_ff - 4'h1;
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_SAR_BIT: assert property (step && !start |=> res_ff[$past(bit_ff)] == $past(cmp))
		else $error("sar bit not taken from comparator");
endmodule : sar_stepper

/* tb/host_link.sv */
// host serial port model that frames one 16-bit transfer at a time
module host_link (
	// clock
	input wire logic hclk,
	// serial pins
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		din = 1'b0;
	end
	// half period of 5 hclk: pins pass sync flops, so full-rate sclk is out of reach
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		@(posedge hclk);
		cs_n <= 1'b0;
		for (int k = 15; k >= 0; k--) begin
			din <= tx[k];
			repeat (5) @(posedge hclk);
			rx[k] = dout;
			sclk <= 1'b0;
			repeat (5) @(posedge hclk);
			sclk <= 1'b1;
		end
		cs_n <= 1'b1;
		// released line shows the inverse, never a stale value
		din <= ~tx[0];
		repeat (6) @(posedge hclk);
	endtask : xfer
endmodule : host_link

/* tb/adc_channel_sequencer_test.sv */
// self-checking bench of the channel sequencer over ahb-lite and the serial pins
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
	$display("BAD t=%0t got %h exp %h", $time, a, b); end end
module adc_channel_sequencer_test import adc_seq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic cs_n;
	logic sclk;
	logic din;
	logic dout;
	logic dout_oe_n;
	logic cmp_in = 1'b0;
	logic [CODE_W-1:0] dac_code;
	logic [CH_W-1:0] mux_sel;
	logic range_sel;
	logic [31:0] rd;
	int failures = 0;
	int num_checks = 0;
	always #10 hclk = ~hclk;
	// comparator of a front end whose input level is {channel, 0x3c}
	always @(posedge hclk) cmp_in <= ({mux_sel, 8'h3c} >= dac_code);
	adc_channel_sequencer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cs_n(cs_n), .sclk(sclk),
		.din(din), .dout(dout), .dout_oe_n(dout_oe_n), .cmp_in(cmp_in), .dac_code(dac_code),
		.mux_sel(mux_sel), .range_sel(range_sel));
	host_link i_host (.hclk(hclk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
	task automatic give_verdict;
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict
	// hready sampled at the rising edge itself, before the slave updates it
	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 20) begin
			@(posedge hclk);
			n++;
		end
		if (hreadyout !== 1'b1) begin
			failures++;
			give_verdict();
		end
	endtask : wait_rdy
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		`CHK(hresp, 1'b0)
	endtask : ahb
	// control word: {write, seq, mask_sel}, address, power bits kept at 3
	function automatic logic [15:0] cw(logic [2:0] wsm, logic [3:0] a, logic r, logic c);
		return {wsm, 1'b0, a, 2'h3, r, c, 4'h0};
	endfunction : cw
	task automatic xchk(input logic [15:0] tx, input logic [3:0] ch, input logic st);
		logic [15:0] rx;
		i_host.xfer(tx, rx);
		`CHK(rx, {ch, ch ^ {~st, 3'h0}, 8'h3c})
		`CHK(dout_oe_n, 1'b1)
		`CHK(dac_code, {ch, 8'h3c})
	endtask : xchk
	// plain transfers, write bit low, expecting a run of channels
	task automatic run(input logic [15:0] list, input int n, input logic st);
		for (int i = 0; i < n; i++) begin
			xchk(16'h0, list[15-4*i -: 4], st);
		end
	endtask : run
	task automatic t_regs;
		ahb(1'b0, A_CTRL, 32'h0);
		`CHK(rd, 32'h00c)
		ahb(1'b1, A_MASK, 32'hffff);
		ahb(1'b0, A_MASK, 32'h0);
		`CHK(rd, 32'h0)
		ahb(1'b0, 8'h10, 32'h0);
		`CHK(rd, 32'h0)
	endtask : t_regs
	task automatic t_single;
		xchk(cw(3'h4, 4'h5, 1'b1, 1'b1), 4'h0, 1'b0);
		`CHK(range_sel, 1'b1)
		ahb(1'b0, A_CTRL, 32'h0);
		`CHK(rd, 32'h85f)
		xchk(cw(3'h4, 4'h9, 1'b0, 1'b0), 4'h5, 1'b1);
		`CHK(range_sel, 1'b0)
		xchk(16'h0, 4'h9, 1'b0);
		ahb(1'b0, A_RESULT, 32'h0);
		`CHK(rd, 32'h913c)
	endtask : t_single
	task automatic t_mask;
		logic [15:0] rx;
		xchk(cw(3'h5, 4'h9, 1'b0, 1'b0), 4'h9, 1'b0);
		// channels 2, 7 and 11; the first serial bit stands for channel 0
		i_host.xfer(16'h2110, rx);
		`CHK(rx, 16'h913c)
		ahb(1'b0, A_MASK, 32'h0);
		`CHK(rd, 32'h0884)
		ahb(1'b0, A_STATUS, 32'h0);
		`CHK(rd, 32'h00a9)
		run(16'h27b2, 4, 1'b0);
		xchk(cw(3'h6, 4'h0, 1'b0, 1'b1), 4'h7, 1'b0);
		xchk(16'h0, 4'hb, 1'b1);
		xchk(cw(3'h4, 4'h3, 1'b0, 1'b1), 4'h2, 1'b1);
		xchk(16'h0, 4'h3, 1'b1);
		xchk(16'h0, 4'h3, 1'b1);
	endtask : t_mask
	task automatic t_cons;
		ahb(1'b1, A_CTRL, 32'he2d);
		run(16'h0120, 4, 1'b1);
		xchk(cw(3'h6, 4'h2, 1'b0, 1'b1), 4'h1, 1'b1);
		run(16'h2010, 3, 1'b1);
		xchk(cw(3'h4, 4'hf, 1'b0, 1'b1), 4'h2, 1'b1);
		xchk(16'h0, 4'hf, 1'b1);
		`CHK(mux_sel, 4'hf)
	endtask : t_cons
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		t_regs();
		t_single();
		t_mask();
		t_cons();
		give_verdict();
	end
endmodule : adc_channel_sequencer_test
